// File: logic/bod_pkg.sv
// Constants and types shared by the brown-out control block
`default_nettype none

package bod_pkg;

    // ****************************************
    // Bus map
    // ****************************************
    localparam int ADDR_W = 9;
    localparam int DATA_W = 32;
    localparam logic [8:0] CTRL_OFFSET = 9'h018;
    localparam logic [8:0] PROT_OFFSET = 9'h100;

    // ****************************************
    // Control word fields
    // ****************************************
    localparam int EN_BIT = 0;
    localparam int VL_LSB = 1;
    localparam int VL_W = 2;
    localparam int RSTSEL_BIT = 3;
    localparam int FLAG_BIT = 4;
    localparam int OUT_BIT = 6;
    localparam int PROT_OPEN_BIT = 0;

    // ****************************************
    // Flash user configuration word fields
    // ****************************************
    localparam int CFG_RSTSEL_BIT = 20;
    localparam int CFG_VL_LSB = 21;
    localparam int CFG_EN_BIT = 23;

    // ****************************************
    // Unlock keys and reset values
    // ****************************************
    localparam logic [7:0] KEY1 = 8'h59;
    localparam logic [7:0] KEY2 = 8'h16;
    localparam logic [7:0] KEY3 = 8'h88;
    localparam logic WAIT_RESET = 1'b1;
    localparam logic FLAG_RESET = 1'b0;
    localparam logic IRQ_RESET = 1'b0;
    localparam logic RST_REQ_RESET = 1'b0;
    localparam logic [31:0] READ_RESET = 32'h0000_0000;
    localparam int SYNC_STAGES = 2;

    // ****************************************
    // Unlock sequence states
    // ****************************************
    typedef enum logic [3:0] {
        LOCK_IDLE = 4'b0001,
        LOCK_KEY1 = 4'b0010,
        LOCK_KEY2 = 4'b0100,
        LOCK_OPEN = 4'b1000
    } lock_state_t;

endpackage

`default_nettype wire

// File: logic/bod_sync.sv
// Level synchroniser for the asynchronous comparator output
`default_nettype none

module bod_sync #(
    parameter int STAGES = bod_pkg::SYNC_STAGES
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic srst_i,
    // Level in and out
    input wire logic async_i,
    output logic sync_o
);

    // ****************************************
    // Flip-flop chain
    // ****************************************
    logic [STAGES-1:0] chain;

    if (STAGES < 2) begin
        $error("bod_sync needs at least two stages");
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            chain <= '0;
        end else begin
            chain <= {chain[STAGES-2:0], async_i};
        end
    end

    assign sync_o = chain[STAGES-1];

    // ****************************************
    // Checks
    // ****************************************
    sync_delay_a: assert property (@(posedge clk_i) disable iff (srst_i)
        !$past(srst_i, STAGES) && !$past(srst_i, 1) |-> sync_o == $past(async_i, STAGES))
        else $error("synchroniser output does not follow its input");

endmodule

`default_nettype wire

// File: logic/bod_unlock.sv
// Unlock key sequence that opens the protected control bits
`default_nettype none

module bod_unlock (
    // Clock and reset
    input wire logic clk_i,
    input wire logic srst_i,
    // Key writes
    input wire logic key_wr_i,
    input wire logic [7:0] key_i,
    // Status
    output logic unlocked_o
);

    // ****************************************
    // Sequence state
    // ****************************************
    bod_pkg::lock_state_t state;
    bod_pkg::lock_state_t next_state;
    bod_pkg::lock_state_t restart;

    assign restart = (key_i == bod_pkg::KEY1) ? bod_pkg::LOCK_KEY1 : bod_pkg::LOCK_IDLE;

    always_comb begin
        next_state = state;
        if (key_wr_i) begin
            unique case (state)
                bod_pkg::LOCK_IDLE: next_state = restart;
                bod_pkg::LOCK_KEY1: begin
                    next_state = (key_i == bod_pkg::KEY2) ? bod_pkg::LOCK_KEY2 : restart;
                end
                bod_pkg::LOCK_KEY2: begin
                    next_state = (key_i == bod_pkg::KEY3) ? bod_pkg::LOCK_OPEN : restart;
                end
                bod_pkg::LOCK_OPEN: next_state = bod_pkg::LOCK_IDLE;
                default: next_state = bod_pkg::LOCK_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            state <= bod_pkg::LOCK_IDLE;
        end else begin
            state <= next_state;
        end
    end

    assign unlocked_o = (state == bod_pkg::LOCK_OPEN);

    // ****************************************
    // Checks
    // ****************************************
    logic [15:0] key_hist;
    logic [1:0] open_hist;

    // Last two keys and the lock state at each of them
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            key_hist <= '0;
            open_hist <= '0;
        end else if (key_wr_i) begin
            key_hist <= {key_hist[7:0], key_i};
            open_hist <= {open_hist[0], unlocked_o};
        end
    end

    sequence key_run_s;
        key_wr_i && key_i == bod_pkg::KEY3 && key_hist == {bod_pkg::KEY1, bod_pkg::KEY2}
            && !open_hist[1];
    endsequence

    open_after_key_a: assert property (@(posedge clk_i) disable iff (srst_i)
        $rose(unlocked_o) |-> $past(key_wr_i) && $past(key_i) == bod_pkg::KEY3)
        else $error("unlocked without the final key");

    pair_then_open_a: assert property (@(posedge clk_i) disable iff (srst_i)
        key_run_s |=> unlocked_o)
        else $error("full key sequence did not unlock");

endmodule

`default_nettype wire

// File: logic/brownout_irq_reset_ctrl.sv
// Brown-out detector control: register slave, crossing flag, reset and interrupt
//
// Behaviour
// - While enabled, set crossing flag when the supply crosses the threshold either way.
// - Writing one clears the crossing flag unless a crossing sets it in the same cycle; writing zero leaves it.
// - Enabled, reset mode, detector output high: request a chip reset.
// - Enabled, interrupt mode, output high: interrupt, held until enable cleared.
// - Interrupt is suppressed by clearing enable or masking it outside.
// - Reset-or-interrupt select loads from flash config bit 20 at reset.
// - Two-bit threshold select at bits 2:1 loads from flash config at reset.
// - Protected bits change only after keys 59h, 16h, 88h are written.
// - Detector output reads one only below threshold, zero when disabled.
// - Enable bit 0 turns detection on when one, off when zero.
`default_nettype none

module brownout_irq_reset_ctrl (
    // Clock and reset
    input wire logic clk_i,
    input wire logic srst_i,
    // Avalon-MM slave
    input wire logic [bod_pkg::ADDR_W-1:0] address_i,
    input wire logic read_i,
    input wire logic write_i,
    input wire logic [bod_pkg::DATA_W-1:0] writedata_i,
    input wire logic [3:0] byteenable_i,
    output logic [bod_pkg::DATA_W-1:0] readdata_o,
    output logic waitrequest_o,
    // Comparator and flash configuration
    input wire logic vdd_below_i,
    input wire logic [31:0] flash_user_config_word_i,
    output logic detector_enable_o,
    output logic [bod_pkg::VL_W-1:0] threshold_select_o,
    // Reset request and interrupt
    output logic chip_rst_req_o,
    output logic brownout_irq_o
);

    // ****************************************
    // Bus decode
    // ****************************************
    logic bus_req;
    logic bus_accept;
    logic sel_ctrl;
    logic sel_prot;
    logic ctrl_wr;
    logic prot_wr;
    logic guarded_wr;
    logic flag_clear;
    logic unlocked;
    logic next_wait;

    assign bus_req = read_i | write_i;
    assign bus_accept = bus_req & ~waitrequest_o;
    assign sel_ctrl = (address_i == bod_pkg::CTRL_OFFSET);
    assign sel_prot = (address_i == bod_pkg::PROT_OFFSET);
    assign ctrl_wr = bus_accept & write_i & sel_ctrl & byteenable_i[0];
    assign prot_wr = bus_accept & write_i & sel_prot & byteenable_i[0];
    assign guarded_wr = ctrl_wr & unlocked;
    assign flag_clear = ctrl_wr & writedata_i[bod_pkg::FLAG_BIT];
    assign next_wait = ~(bus_req & waitrequest_o);

    // ****************************************
    // Unlock sequence
    // ****************************************
    bod_unlock u_unlock (
        .clk_i(clk_i),
        .srst_i(srst_i),
        .key_wr_i(prot_wr),
        .key_i(writedata_i[7:0]),
        .unlocked_o(unlocked)
    );

    // ****************************************
    // Comparator synchroniser
    // ****************************************
    logic below_sync;
    logic below_prev;

    bod_sync #(
        .STAGES(bod_pkg::SYNC_STAGES)
    ) u_sync (
        .clk_i(clk_i),
        .srst_i(srst_i),
        .async_i(vdd_below_i),
        .sync_o(below_sync)
    );

    // ****************************************
    // Control state
    // ****************************************
    logic detector_enable;
    logic [bod_pkg::VL_W-1:0] threshold_select;
    logic reset_not_irq_select;
    logic crossing_flag;
    logic detector_output;
    logic crossing_evt;
    logic next_flag;
    logic irq_cause;
    logic next_irq;

    assign crossing_evt = detector_enable & (below_sync != below_prev);
    assign next_flag = crossing_evt | (crossing_flag & ~flag_clear);
    assign irq_cause = ~reset_not_irq_select & detector_output;
    assign next_irq = detector_enable & (brownout_irq_o | irq_cause);

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            detector_enable <= flash_user_config_word_i[bod_pkg::CFG_EN_BIT];
            threshold_select <= flash_user_config_word_i[bod_pkg::CFG_VL_LSB +: bod_pkg::VL_W];
            reset_not_irq_select <= flash_user_config_word_i[bod_pkg::CFG_RSTSEL_BIT];
        end else if (guarded_wr) begin
            detector_enable <= writedata_i[bod_pkg::EN_BIT];
            threshold_select <= writedata_i[bod_pkg::VL_LSB +: bod_pkg::VL_W];
            reset_not_irq_select <= writedata_i[bod_pkg::RSTSEL_BIT];
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            below_prev <= 1'b0;
            crossing_flag <= bod_pkg::FLAG_RESET;
            detector_output <= 1'b0;
        end else begin
            below_prev <= below_sync;
            crossing_flag <= next_flag;
            detector_output <= detector_enable & below_sync;
        end
    end

    // ****************************************
    // Reset request and interrupt
    // ****************************************
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            chip_rst_req_o <= bod_pkg::RST_REQ_RESET;
            brownout_irq_o <= bod_pkg::IRQ_RESET;
        end else begin
            chip_rst_req_o <= detector_enable & reset_not_irq_select & detector_output;
            brownout_irq_o <= next_irq;
        end
    end

    assign detector_enable_o = detector_enable;
    assign threshold_select_o = threshold_select;

    // ****************************************
    // Read data and waitrequest
    // ****************************************
    logic [bod_pkg::DATA_W-1:0] ctrl_word;
    logic [bod_pkg::DATA_W-1:0] prot_word;
    logic [bod_pkg::DATA_W-1:0] read_word;

    always_comb begin
        ctrl_word = '0;
        ctrl_word[bod_pkg::EN_BIT] = detector_enable;
        ctrl_word[bod_pkg::VL_LSB +: bod_pkg::VL_W] = threshold_select;
        ctrl_word[bod_pkg::RSTSEL_BIT] = reset_not_irq_select;
        ctrl_word[bod_pkg::FLAG_BIT] = crossing_flag;
        ctrl_word[bod_pkg::OUT_BIT] = detector_output;
    end

    always_comb begin
        prot_word = '0;
        prot_word[bod_pkg::PROT_OPEN_BIT] = unlocked;
    end

    assign read_word = sel_ctrl ? ctrl_word : (sel_prot ? prot_word : '0);

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            waitrequest_o <= bod_pkg::WAIT_RESET;
            readdata_o <= bod_pkg::READ_RESET;
        end else begin
            waitrequest_o <= next_wait;
            if (bus_req && waitrequest_o) begin
                readdata_o <= read_i ? read_word : '0;
            end
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    default clocking main_cb @(posedge clk_i);
    endclocking

    default disable iff (srst_i);

    sequence ctrl_write_s;
        ctrl_wr;
    endsequence

    sequence locked_write_s;
        ctrl_wr && !unlocked;
    endsequence

    sequence disabled_s;
        !detector_enable;
    endsequence

    flag_set_a: assert property (
        detector_enable && below_sync != below_prev |=> crossing_flag)
        else $error("crossing did not set the flag");

    flag_clear_a: assert property (
        ctrl_write_s and (writedata_i[bod_pkg::FLAG_BIT] && !crossing_evt) |=> !crossing_flag)
        else $error("written one did not clear the flag");

    flag_keep_a: assert property (
        ctrl_write_s and (!writedata_i[bod_pkg::FLAG_BIT] && crossing_flag) |=> crossing_flag)
        else $error("written zero disturbed the flag");

    reset_request_a: assert property (
        detector_enable && reset_not_irq_select && detector_output |=> chip_rst_req_o)
        else $error("reset request missing");

    reset_only_mode_a: assert property (
        chip_rst_req_o |-> $past(reset_not_irq_select) && $past(detector_enable))
        else $error("reset request without reset mode");

    irq_raise_a: assert property (
        detector_enable && !reset_not_irq_select && detector_output |=> brownout_irq_o)
        else $error("interrupt not raised");

    irq_hold_a: assert property (
        brownout_irq_o && detector_enable |=> brownout_irq_o)
        else $error("interrupt dropped while enabled");

    irq_disable_a: assert property (
        disabled_s |=> !brownout_irq_o)
        else $error("interrupt present while disabled");

    out_disabled_a: assert property (
        disabled_s |=> !detector_output)
        else $error("detector output high while disabled");

    lock_guard_a: assert property (
        locked_write_s |=> $stable(threshold_select) && $stable(reset_not_irq_select)
            && $stable(detector_enable))
        else $error("protected bits changed while locked");

    enable_write_a: assert property (
        ctrl_write_s and unlocked |=> detector_enable == $past(writedata_i[bod_pkg::EN_BIT]))
        else $error("enable bit not taken");

    reset_load_a: assert property (@(posedge clk_i) disable iff (1'b0)
        srst_i |=> reset_not_irq_select == $past(flash_user_config_word_i[bod_pkg::CFG_RSTSEL_BIT]))
        else $error("mode select not loaded from flash");

    thresh_load_a: assert property (@(posedge clk_i) disable iff (1'b0)
        srst_i |=> threshold_select
            == $past(flash_user_config_word_i[bod_pkg::CFG_VL_LSB +: bod_pkg::VL_W]))
        else $error("threshold not loaded from flash");

    bus_answer_a: assert property (
        bus_req && waitrequest_o ##1 bus_req |-> !waitrequest_o ##1 waitrequest_o)
        else $error("bus answer not in one cycle");

    flag_rise_a: assert property (
        detector_enable && $rose(below_sync) |=> crossing_flag)
        else $error("falling supply did not set the flag");

    flag_fall_a: assert property (
        detector_enable && $fell(below_sync) |=> crossing_flag)
        else $error("rising supply did not set the flag");

    flag_quiet_a: assert property (
        !crossing_evt && !crossing_flag |=> !crossing_flag)
        else $error("flag set without a crossing");

    irq_cause_a: assert property (
        $rose(brownout_irq_o) |-> $past(detector_output) && !$past(reset_not_irq_select))
        else $error("interrupt raised without its cause");

    irq_enable_a: assert property (
        brownout_irq_o |-> $past(detector_enable))
        else $error("interrupt present after enable cleared");

    reset_drop_a: assert property (
        !detector_output |=> !chip_rst_req_o)
        else $error("reset request without detector output");

    out_high_a: assert property (
        detector_enable && below_sync |=> detector_output)
        else $error("detector output low while below threshold");

    out_low_a: assert property (
        !below_sync |=> !detector_output)
        else $error("detector output high above threshold");

    thresh_write_a: assert property (
        ctrl_write_s and unlocked |=> threshold_select
            == $past(writedata_i[bod_pkg::VL_LSB +: bod_pkg::VL_W]))
        else $error("threshold not taken");

    mode_write_a: assert property (
        ctrl_write_s and unlocked |=> reset_not_irq_select
            == $past(writedata_i[bod_pkg::RSTSEL_BIT]))
        else $error("mode select not taken");

    byte_guard_a: assert property (
        bus_accept && write_i && !byteenable_i[0] |=> $stable(threshold_select)
            && $stable(reset_not_irq_select) && $stable(detector_enable))
        else $error("write without byte zero changed a bit");

    wait_idle_a: assert property (
        !bus_req |=> waitrequest_o)
        else $error("waitrequest low without a request");

    read_ctrl_a: assert property (
        bus_req && waitrequest_o && read_i && sel_ctrl |=> readdata_o == $past(ctrl_word))
        else $error("control read data wrong");

endmodule

`default_nettype wire

// File: dv/brownout_irq_reset_ctrl_tb_top.sv
// Self-checking bench for the brown-out control block
`default_nettype none

`define CHK(got, exp) begin \
    total_checks++; \
    if ((got) !== (exp)) begin \
        errors++; \
        $display("unexpected at %0t: got %h expected %h", $time, got, exp); \
    end \
end

module brownout_irq_reset_ctrl_tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk_i;
    logic srst_i;
    logic [8:0] address_i;
    logic read_i;
    logic write_i;
    logic [31:0] writedata_i;
    logic [3:0] byteenable_i;
    logic [31:0] readdata_o;
    logic waitrequest_o;
    logic vdd_below_i;
    logic [31:0] flash_user_config_word_i;
    logic detector_enable_o;
    logic [1:0] threshold_select_o;
    logic chip_rst_req_o;
    logic brownout_irq_o;
    int errors;
    int total_checks;
    logic [31:0] rd;
    logic [31:0] cfg;
    logic [1:0] thr;

    brownout_irq_reset_ctrl u_brownout_irq_reset_ctrl (
        .clk_i(clk_i),
        .srst_i(srst_i),
        .address_i(address_i),
        .read_i(read_i),
        .write_i(write_i),
        .writedata_i(writedata_i),
        .byteenable_i(byteenable_i),
        .readdata_o(readdata_o),
        .waitrequest_o(waitrequest_o),
        .vdd_below_i(vdd_below_i),
        .flash_user_config_word_i(flash_user_config_word_i),
        .detector_enable_o(detector_enable_o),
        .threshold_select_o(threshold_select_o),
        .chip_rst_req_o(chip_rst_req_o),
        .brownout_irq_o(brownout_irq_o)
    );

    // ****************************************
    // Clock and watchdog
    // ****************************************
    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end

    initial begin
        #1_000_000;
        errors++;
        tally_and_finish();
    end

    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [31:0] exp_ctrl(input logic en, input logic [1:0] th,
                                             input logic rm, input logic fl, input logic o);
        return {25'h000_0000, o, 1'b0, fl, rm, th, en};
    endfunction

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Avalon access: hold until waitrequest low is sampled at a rising edge
    task automatic bus(input logic wr, input logic [8:0] a, input logic [31:0] d,
                       input logic [3:0] be, output logic [31:0] q);
        int n;
        @(posedge clk_i);
        read_i <= ~wr;
        write_i <= wr;
        address_i <= a;
        writedata_i <= d;
        byteenable_i <= be;
        for (n = 0; n < 20; n++) begin
            @(posedge clk_i);
            if (waitrequest_o === 1'b0) begin
                break;
            end
        end
        if (n == 20) begin
            errors++;
            tally_and_finish();
        end
        q = readdata_o;
        read_i <= 1'b0;
        write_i <= 1'b0;
    endtask

    task automatic wr(input logic [8:0] a, input logic [31:0] d);
        bus(1'b1, a, d, 4'hf, rd);
    endtask

    task automatic rd_chk(input logic [8:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0000_0000, 4'hf, rd);
        `CHK(rd, e)
    endtask

    task automatic do_reset(input logic [31:0] c);
        @(posedge clk_i);
        flash_user_config_word_i <= c;
        vdd_below_i <= 1'b0;
        srst_i <= 1'b1;
        repeat (5) @(posedge clk_i);
        srst_i <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic settle();
        repeat (6) @(posedge clk_i);
        @(negedge clk_i);
    endtask

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        errors = 0;
        total_checks = 0;
        srst_i = 1'b1;
        address_i = 9'h000;
        read_i = 1'b0;
        write_i = 1'b0;
        writedata_i = 32'h0000_0000;
        byteenable_i = 4'h0;
        vdd_below_i = 1'b0;
        flash_user_config_word_i = 32'h0000_0000;
        void'($urandom(32'h6e65));

        // Defaults from random flash words
        repeat (3) begin
            cfg = $urandom;
            do_reset(cfg);
            `CHK(detector_enable_o, cfg[23])
            `CHK(threshold_select_o, cfg[22:21])
            `CHK(chip_rst_req_o, 1'b0)
            rd_chk(bod_pkg::CTRL_OFFSET, exp_ctrl(cfg[23], cfg[22:21], cfg[20], 1'b0, 1'b0));
        end
        $display("test defaults done");

        // Enabled, interrupt mode, threshold 2
        do_reset(32'h00c0_0000);
        rd_chk(9'h004, 32'h0000_0000);
        wr(bod_pkg::CTRL_OFFSET, 32'h0000_000a);
        rd_chk(bod_pkg::CTRL_OFFSET, exp_ctrl(1'b1, 2'b10, 1'b0, 1'b0, 1'b0));
        $display("test locked done");

        vdd_below_i <= 1'b1;
        settle();
        `CHK(brownout_irq_o, 1'b1)
        `CHK(chip_rst_req_o, 1'b0)
        rd_chk(bod_pkg::CTRL_OFFSET, exp_ctrl(1'b1, 2'b10, 1'b0, 1'b1, 1'b1));
        wr(bod_pkg::CTRL_OFFSET, 32'h0000_0010);
        rd_chk(bod_pkg::CTRL_OFFSET, exp_ctrl(1'b1, 2'b10, 1'b0, 1'b0, 1'b1));
        vdd_below_i <= 1'b0;
        settle();
        `CHK(brownout_irq_o, 1'b1)
        rd_chk(bod_pkg::CTRL_OFFSET, exp_ctrl(1'b1, 2'b10, 1'b0, 1'b1, 1'b0));
        wr(bod_pkg::CTRL_OFFSET, 32'h0000_0000);
        rd_chk(bod_pkg::CTRL_OFFSET, exp_ctrl(1'b1, 2'b10, 1'b0, 1'b1, 1'b0));
        wr(bod_pkg::CTRL_OFFSET, 32'h0000_0010);
        $display("test interrupt done");

        // Unlock, then disable
        wr(bod_pkg::PROT_OFFSET, {24'h00_0000, bod_pkg::KEY1});
        wr(bod_pkg::PROT_OFFSET, {24'h00_0000, bod_pkg::KEY2});
        wr(bod_pkg::PROT_OFFSET, {24'h00_0000, bod_pkg::KEY3});
        rd_chk(bod_pkg::PROT_OFFSET, 32'h0000_0001);
        bus(1'b1, bod_pkg::CTRL_OFFSET, 32'h0000_0000, 4'he, rd);
        @(negedge clk_i);
        `CHK(detector_enable_o, 1'b1)
        wr(bod_pkg::CTRL_OFFSET, 32'h0000_0000);
        settle();
        `CHK(detector_enable_o, 1'b0)
        `CHK(brownout_irq_o, 1'b0)
        vdd_below_i <= 1'b1;
        settle();
        `CHK(brownout_irq_o, 1'b0)
        rd_chk(bod_pkg::CTRL_OFFSET, exp_ctrl(1'b0, 2'b00, 1'b0, 1'b0, 1'b0));
        $display("test disable done");

        // Reset mode while below threshold
        wr(bod_pkg::CTRL_OFFSET, 32'h0000_0009);
        settle();
        `CHK(chip_rst_req_o, 1'b1)
        `CHK(brownout_irq_o, 1'b0)
        rd_chk(bod_pkg::CTRL_OFFSET, exp_ctrl(1'b1, 2'b00, 1'b1, 1'b0, 1'b1));
        vdd_below_i <= 1'b0;
        settle();
        `CHK(chip_rst_req_o, 1'b0)
        rd_chk(bod_pkg::CTRL_OFFSET, exp_ctrl(1'b1, 2'b00, 1'b1, 1'b1, 1'b0));
        wr(bod_pkg::CTRL_OFFSET, 32'h0000_0010);
        $display("test reset mode done");

        // Random thresholds while open, then relock
        repeat (4) begin
            thr = 2'($urandom);
            wr(bod_pkg::CTRL_OFFSET, {29'h0000_0000, thr, 1'b0});
            @(negedge clk_i);
            `CHK(threshold_select_o, thr)
            rd_chk(bod_pkg::CTRL_OFFSET, exp_ctrl(1'b0, thr, 1'b0, 1'b0, 1'b0));
        end
        wr(bod_pkg::PROT_OFFSET, 32'h0000_0000);
        rd_chk(bod_pkg::PROT_OFFSET, 32'h0000_0000);
        wr(bod_pkg::CTRL_OFFSET, {29'h0000_0000, ~thr, 1'b1});
        @(negedge clk_i);
        `CHK(threshold_select_o, thr)
        `CHK(detector_enable_o, 1'b0)
        $display("test threshold done");

        tally_and_finish();
    end
endmodule

`default_nettype wire
